// File: src/res_exception_seq.sv
// reset and interrupt exception entry sequencer
//
// Function
// - reset outranks every interrupt
// - reset handling starts right after release
// - interrupts enter only at instruction boundaries
// - reset low halts everything immediately
// - reset initialises state, sets mask bit
// - load PC from vector at 0000/0001
// - interrupts masked right after reset handling
// - first instruction runs before any interrupt
// - mask set: flags latch in run or entry state only, none accepted
// - highest priority pending interrupt served first
`timescale 1ns/10ps
module res_exception_seq
  import res_pkg::*;
#(
  parameter int IRQ_N = RES_IRQ_N
) (
  input  wire logic                  mclk_in,
  input  wire logic                  rstn_in,
  input  wire logic                  reset_in_n,
  input  wire logic [IRQ_N-1:0]      irq_req_in,
  input  wire logic                  irq_clr_in,
  input  wire logic [IRQ_N-1:0]      irq_clr_mask_in,
  input  wire logic                  mem_ack_in,
  input  wire logic [7:0]            mem_rdata_in,
  input  wire logic                  insn_done_in,
  input  wire logic                  ccr_wr_in,
  input  wire logic [7:0]            ccr_wdata_in,
  output res_mem_req_s               mem_req_out,
  output logic                       periph_init_out,
  output logic                       core_run_out,
  output logic                       pc_load_out,
  output logic [15:0]                pc_out,
  output logic                       irq_take_out,
  output logic [15:0]                irq_vec_out,
  output logic [IRQ_N-1:0]           irq_flags_out,
  output logic [7:0]                 condition_flags_reg_out
);

  // ==========================================================
  // reset pin synchroniser; low forces the reset state at once
  logic       rst_s1;
  logic       rst_s2;
  // either source clears the synchroniser without waiting for a clock
  wire logic  pin_rst_n = rstn_in & reset_in_n;

  always_ff @(posedge mclk_in or negedge pin_rst_n) begin
    if (!pin_rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  // the async assert halts at once; release is synchronised
  // so every state flop leaves reset on one and the same edge
  wire logic core_rst_n = rst_s2;

  // ==========================================================
  // sequencer state
  res_state_e        state;
  res_state_e        next_state;
  logic [7:0]        vec_hi;
  logic [7:0]        condition_flags_reg;
  logic [IRQ_N-1:0]  irq_flags;
  logic              first_insn_done;

  // ==========================================================
  // interrupt priority: lowest index is highest priority
  localparam int SEL_W = (IRQ_N > 1) ? $clog2(IRQ_N) : 1;
  wire logic [IRQ_N:0]   below_set;
  wire logic [IRQ_N-1:0] irq_win;
  logic [SEL_W-1:0]      irq_sel;

  // a flag wins when no flag of lower index is set
  assign below_set[0] = 1'b0;
  for (genvar g = 0; g < IRQ_N; g++) begin : g_prio
    assign below_set[g+1] = below_set[g] | irq_flags[g];
    assign irq_win[g]     = irq_flags[g] & ~below_set[g];
  end

  // irq_win is one-hot or zero, so an or of indices is exact
  always_comb begin
    irq_sel = '0;
    for (int i = 0; i < IRQ_N; i++) begin
      if (irq_win[i]) begin
        irq_sel = irq_sel | SEL_W'(i);
      end
    end
  end

  wire logic imask    = condition_flags_reg[RES_CCR_IMASK_BIT];
  wire logic any_irq  = below_set[IRQ_N];
  wire logic in_run   = state == RES_ST_RUN;
  wire logic in_entry = state == RES_ST_IRQ_ENTRY;
  wire logic hi_ack   = state == RES_ST_VEC_HI && mem_ack_in;
  wire logic lo_ack   = state == RES_ST_VEC_LO && mem_ack_in;
  // accept only after first instruction and with mask clear
  wire logic irq_ok   = any_irq && !imask && first_insn_done;
  // an entry in progress is never cut short by a second one
  wire logic take_irq = in_run && insn_done_in && irq_ok;

  // vector reads wait for the bus without limit; a bus that never
  // acknowledges leaves the core in the fetch states
  always_comb begin
    next_state = state;
    case (state)
      RES_ST_RESET:     next_state = RES_ST_INIT;
      RES_ST_INIT:      next_state = RES_ST_VEC_HI;
      RES_ST_VEC_HI:    if (mem_ack_in) next_state = RES_ST_VEC_LO;
      RES_ST_VEC_LO:    if (mem_ack_in) next_state = RES_ST_RUN;
      RES_ST_RUN:       if (take_irq) next_state = RES_ST_IRQ_ENTRY;
      RES_ST_IRQ_ENTRY: if (insn_done_in) next_state = RES_ST_RUN;
      default:          next_state = RES_ST_RESET;
    endcase
  end

  // ==========================================================
  // the reset path always wins over any interrupt activity
  always_ff @(posedge mclk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state <= RES_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      vec_hi <= 8'h00;
    end else if (hi_ack) begin
      vec_hi <= mem_rdata_in;
    end
  end

  always_ff @(posedge mclk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      condition_flags_reg <= RES_CCR_RESET;
    end else if (take_irq) begin
      condition_flags_reg[RES_CCR_IMASK_BIT] <= 1'b1;
    end else if (ccr_wr_in && in_run) begin
      condition_flags_reg <= ccr_wdata_in;
    end
  end

  // flags latch in run or entry even when masked; a new request beats a clear
  // taking an interrupt clears only the winning flag
  logic [IRQ_N-1:0] next_flags;
  logic [IRQ_N-1:0] clr_bits;
  always_comb begin
    clr_bits = irq_clr_in ? irq_clr_mask_in : '0;
    if (take_irq) begin
      clr_bits[irq_sel] = 1'b1;
    end
    next_flags = (irq_flags & ~clr_bits) | irq_req_in;
  end

  always_ff @(posedge mclk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      irq_flags <= '0;
    end else if (in_run || in_entry) begin
      irq_flags <= next_flags;
    end
  end

  always_ff @(posedge mclk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      first_insn_done <= 1'b0;
    end else if (in_run && insn_done_in) begin
      first_insn_done <= 1'b1;
    end
  end

  // ==========================================================
  // vector load and interrupt entry outputs, registered
  always_ff @(posedge mclk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      pc_load_out <= 1'b0;
      pc_out      <= 16'h0000;
    end else begin
      pc_load_out <= lo_ack;
      if (lo_ack) begin
        pc_out <= {vec_hi, mem_rdata_in};
      end
    end
  end

  // two bytes per vector slot, counted from the base slot
  always_ff @(posedge mclk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      irq_take_out <= 1'b0;
      irq_vec_out  <= 16'h0000;
    end else begin
      irq_take_out <= take_irq;
      if (take_irq) begin
        irq_vec_out <= RES_IRQ_VEC_BASE + 16'({irq_sel, 1'b0});
      end
    end
  end

  // ==========================================================
  // output decode
  // request and address follow the state, so a bus that answers
  // in the same cycle is served without an extra wait
  wire logic fetch_hi = state == RES_ST_VEC_HI;
  wire logic fetch_lo = state == RES_ST_VEC_LO;

  assign mem_req_out.req  = fetch_hi | fetch_lo;
  assign mem_req_out.addr = fetch_lo ? RES_VEC_LO_ADDR
                                     : RES_VEC_HI_ADDR;
  assign periph_init_out  = (state == RES_ST_RESET)
                            || (state == RES_ST_INIT);
  assign core_run_out     = state == RES_ST_RUN;
  assign irq_flags_out    = irq_flags;
  assign condition_flags_reg_out = condition_flags_reg;

endmodule : res_exception_seq

// File: src/res_pkg.sv
// package for the reset and exception entry sequencer
package res_pkg;
  // ==========================================================
  // vector addresses and widths
  localparam int          RES_ADDR_W      = 16;
  localparam int          RES_DATA_W      = 8;
  localparam int          RES_IRQ_N       = 8;
  localparam logic [15:0] RES_VEC_HI_ADDR = 16'h0000;
  localparam logic [15:0] RES_VEC_LO_ADDR = 16'h0001;
  localparam logic [15:0] RES_IRQ_VEC_BASE = 16'h0008;
  // ==========================================================
  // condition flags layout and reset value
  localparam int          RES_CCR_IMASK_BIT = 7;
  localparam logic [7:0]  RES_CCR_RESET     = 8'h80;
  // least reset pulse while running, in system clocks
  localparam int          RES_MIN_LOW_CYC   = 10;

  typedef enum logic [2:0] {
    RES_ST_RESET,
    RES_ST_INIT,
    RES_ST_VEC_HI,
    RES_ST_VEC_LO,
    RES_ST_RUN,
    RES_ST_IRQ_ENTRY
  } res_state_e;

  // memory read request toward the bus
  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } res_mem_req_s;
endpackage : res_pkg

// File: sim/res_sva.sv
// assertions for the exception entry sequencer
`timescale 1ns/10ps
module res_sva
  import res_pkg::*;
(
  input wire logic         mclk_in,
  input wire logic         rstn_in,
  input wire logic         reset_in_n,
  input wire logic         mem_ack_in,
  input wire logic [7:0]   mem_rdata_in,
  input wire logic         insn_done_in,
  input wire res_mem_req_s mem_req_out,
  input wire logic         periph_init_out,
  input wire logic         core_run_out,
  input wire logic         pc_load_out,
  input wire logic [15:0]  pc_out,
  input wire logic         irq_take_out,
  input wire logic [7:0]   condition_flags_reg_out
);
  logic [7:0] hi_q;
  logic       fresh;
  wire        ack_hi = mem_req_out.req && mem_ack_in
                       && mem_req_out.addr == RES_VEC_HI_ADDR;
  wire        ack_lo = mem_req_out.req && mem_ack_in
                       && mem_req_out.addr == RES_VEC_LO_ADDR;
  wire        mask   = condition_flags_reg_out[RES_CCR_IMASK_BIT];
  always_ff @(posedge mclk_in) if (ack_hi) hi_q <= mem_rdata_in;
  // high from vector load until the first instruction ends
  always_ff @(posedge mclk_in or negedge rstn_in)
    if (!rstn_in) fresh <= 1'b0;
    else fresh <= (pc_load_out | fresh) & ~insn_done_in;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in || !reset_in_n);
  sequence s_lo_asked;
    mem_req_out.req && mem_req_out.addr == RES_VEC_LO_ADDR;
  endsequence
  a_halt_at_once: assert property (disable iff (!rstn_in)
    !reset_in_n |-> periph_init_out && !core_run_out
    && !mem_req_out.req && !irq_take_out) else $error("reset not halting");
  a_vec_start: assert property ($rose(reset_in_n) |-> ##[1:8]
    mem_req_out.req && mem_req_out.addr == RES_VEC_HI_ADDR)
    else $error("no vector fetch");
  a_hi_then_lo: assert property (ack_hi |=> s_lo_asked)
    else $error("low byte not next");
  a_pc_pair: assert property (ack_lo |=> pc_load_out
    && pc_out == {hi_q, $past(mem_rdata_in)}) else $error("bad pc");
  a_mask_on_run: assert property ($rose(core_run_out) |-> mask)
    else $error("mask clear at run");
  a_first_insn: assert property ((fresh || pc_load_out) |=>
    !irq_take_out) else $error("irq before first insn");
  a_mask_refuse: assert property (mask |=> !irq_take_out)
    else $error("irq while masked");
  a_irq_boundary: assert property (irq_take_out |->
    $past(insn_done_in) && $past(core_run_out)) else $error("irq mid insn");
endmodule : res_sva
bind res_exception_seq res_sva u_sva (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .reset_in_n(reset_in_n), .mem_ack_in(mem_ack_in),
  .mem_rdata_in(mem_rdata_in), .insn_done_in(insn_done_in),
  .mem_req_out(mem_req_out), .periph_init_out(periph_init_out),
  .core_run_out(core_run_out), .pc_load_out(pc_load_out), .pc_out(pc_out),
  .irq_take_out(irq_take_out),
  .condition_flags_reg_out(condition_flags_reg_out));

// File: sim/res_rst_src.sv
// external reset source driving the reset pin
`timescale 1ns/10ps
module res_rst_src
  import res_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic go_in,
  output logic      reset_in_n
);
  // low from power-up until the clock settles
  int cnt = 20;
  always @(posedge mclk_in)
    if (go_in) cnt <= RES_MIN_LOW_CYC;
    else if (cnt > 0) cnt <= cnt - 1;
  assign reset_in_n = (cnt == 0);
endmodule : res_rst_src

// File: sim/res_exception_seq_bench.sv
// bench for the exception entry sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module res_exception_seq_bench
  import res_pkg::*;
;
  logic clk = 0, rstn = 0, go = 0, ack_en = 1, done = 0, wr = 0, clr = 0;
  logic rst_n, load, run, take, init;
  logic [7:0] irq = 0, cmask = 0, flags, cfr;
  logic [15:0] vec = 0, pc, ivec;
  res_mem_req_s req;
  int errors = 0, comparisons = 0;
  wire ack = req.req & ack_en;
  // released data lines show the inverted low vector byte
  wire [7:0] rd = !ack ? ~vec[7:0] : req.addr[0] ? vec[7:0] : vec[15:8];
  res_rst_src src (.mclk_in(clk), .go_in(go), .reset_in_n(rst_n));
  res_exception_seq dut (.mclk_in(clk), .rstn_in(rstn), .reset_in_n(rst_n),
    .irq_req_in(irq), .irq_clr_in(clr), .irq_clr_mask_in(cmask),
    .mem_ack_in(ack), .mem_rdata_in(rd), .insn_done_in(done),
    .ccr_wr_in(wr), .ccr_wdata_in(8'h00), .mem_req_out(req),
    .periph_init_out(init), .core_run_out(run), .pc_load_out(load),
    .pc_out(pc), .irq_take_out(take), .irq_vec_out(ivec),
    .irq_flags_out(flags), .condition_flags_reg_out(cfr));
  initial forever #25 clk = ~clk;
  task step(); @(posedge clk); #1; endtask : step
  task end_sim();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // ==========================================================
  // scenarios; vector answer is stalled two cycles
  task boot(input logic [15:0] v);
    vec = v;
    ack_en = 0;
    repeat (40) if (!req.req) step();
    step();
    step();
    ack_en = 1;
    repeat (10) if (!load) step();
    `CHK(pc, v)
    `CHK({run, cfr[RES_CCR_IMASK_BIT]}, 2'b11)
  endtask : boot
  task t_irq();
    irq = 8'h0C;
    done = 1;
    step();
    irq = 0;
    done = 0;
    step();
    `CHK({take, flags}, 9'h00C)
    wr = 1;
    done = 1;
    step();
    wr = 0;
    step();
    done = 0;
    `CHK(take, 1'b1)
    `CHK(ivec, RES_IRQ_VEC_BASE + 16'h0004)
    `CHK(flags, 8'h08)
  endtask : t_irq
  // request during entry beats a clear; entry ends before next take
  task t_clr();
    irq = 8'h01;
    clr = 1;
    cmask = 8'h09;
    done = 1;
    step();
    irq = 0;
    clr = 0;
    cmask = 0;
    done = 0;
    wr = 1;
    `CHK({take, flags}, 9'h001)
    step();
    wr = 0;
    done = 1;
    step();
    done = 0;
    `CHK({take, cfr[RES_CCR_IMASK_BIT]}, 2'b11)
    `CHK({ivec, flags}, {RES_IRQ_VEC_BASE, 8'h00})
  endtask : t_clr
  task t_run_reset();
    go = 1;
    step();
    go = 0;
    `CHK({run, init, take}, 3'b010)
    boot(16'hA5C3);
    `CHK(flags, 8'h00)
  endtask : t_run_reset
  initial begin
    repeat (20) @(posedge clk);
    #1 rstn = 1;
    boot(16'h1234);
    t_irq();
    t_clr();
    t_run_reset();
    end_sim();
  end
  initial begin
    #100000;
    errors++;
    end_sim();
  end
endmodule : res_exception_seq_bench
